//--- plsc_pkg.sv
// Constants shared by the phase locked sample clock and its sample timer.
// Assumes a single 20 MHz clock and a 60 Hz nominal power system.
package plsc_pkg;

	// -------------------------------------------------------------
	// Clock and sampling geometry
	// -------------------------------------------------------------
	localparam int unsigned CLK_HZ             = 20_000_000;  // Oscillator rate
	localparam int unsigned LINE_HZ            = 60;          // Nominal power frequency
	localparam int unsigned SAMPLES_PER_CYCLE  = 64;          // One tick per 1/64 cycle
	localparam int          FRAC_BITS          = 16;          // Fraction part of period
	localparam int          INT_BITS           = 16;          // Integer part of period
	localparam int          TS_BITS            = 8;           // Timestamp counter width
	localparam int          SEQ_BITS           = 4;           // Sequence number width
	localparam int          CYC_BITS           = 6;           // Sample index within a cycle

	// Nominal sample period, Q16.16 oscillator counts
	localparam logic [31:0] NOMINAL_PERIOD_Q   =
		32'((64'(CLK_HZ) << FRAC_BITS) / (LINE_HZ * SAMPLES_PER_CYCLE));
	localparam logic [15:0] NOMINAL_INT        = NOMINAL_PERIOD_Q[31:16];

	// -------------------------------------------------------------
	// Timer counts
	// -------------------------------------------------------------
	localparam logic [15:0] CNT_LAST           = 16'h0001;    // Count runs N down to 1
	localparam logic [1:0]  SUB_LAST           = 2'h3;        // Fourth sample of a group
	localparam logic [7:0]  TS_LAST            = 8'hff;       // Timestamp wrap point
	localparam logic [5:0]  CYCLE_FIRST        = 6'h00;       // First sample of a cycle

	// -------------------------------------------------------------
	// Loop filter time constants and gains (Q32 fixed point)
	// -------------------------------------------------------------
	localparam longint unsigned T_PHASE_S      = 10;          // Phase loop, seconds
	localparam longint unsigned T_FREQ_S       = 1000;        // Frequency loop, seconds
	localparam longint unsigned T_REPEAT_DIV   = 60;          // Step is 1/60 second
	localparam longint unsigned KP_NUM         = 2;           // Proportional numerator
	localparam longint unsigned SLEW_DIV       = 10_000;      // Slew 1/10000 Hz per second
	localparam int              GAIN_SHIFT     = 32;
	localparam longint unsigned GAIN_ONE       = 64'h1 << GAIN_SHIFT;
	localparam logic [31:0] INTEGRAL_GAIN_Q    =
		32'(GAIN_ONE / (T_REPEAT_DIV * T_PHASE_S * T_PHASE_S));
	localparam logic [31:0] PROPORTIONAL_GAIN_Q = 32'((KP_NUM * GAIN_ONE) / T_PHASE_S);
	localparam logic [31:0] FREQUENCY_GAIN_Q   = 32'(GAIN_ONE / (T_REPEAT_DIV * T_FREQ_S));
	// Largest period change per execution from the frequency path
	localparam logic [31:0] SLEW_STEP_Q        =
		32'(64'(NOMINAL_PERIOD_Q) / (LINE_HZ * SLEW_DIV * T_REPEAT_DIV));
	localparam logic signed [71:0] SLEW_LIMIT_I = 72'(SLEW_STEP_Q) <<< GAIN_SHIFT;

	// -------------------------------------------------------------
	// Timestamp exchange arithmetic (ticks of 1/64 cycle)
	// -------------------------------------------------------------
	localparam logic signed [11:0] ROLL_DELAY  = 12'sh100;    // Round trip rollover fix
	localparam logic signed [11:0] ROLL_OFFSET = 12'sh080;    // Offset rollover fix
	localparam logic [31:0] HALF_CYCLE_X2      = 32'h0000_0040; // Half cycle, doubled
	localparam logic signed [44:0] PHASE_MAX_Q = 45'sh0000_7fff_ffff;
	localparam logic signed [44:0] PHASE_MIN_Q = -45'sh0000_8000_0000;

	// Magnitude of a signed word, used for range and lock checks
	function automatic logic [31:0] plsc_abs32(input logic signed [31:0] v);
		plsc_abs32 = v[31] ? 32'(-v) : 32'(v);
	endfunction

endpackage

//--- plsc_period_if.sv
// Carrier between the loop filter and the sample timer.
// Assumes both ends share one clock; no crossing inside.
interface plsc_period_if;
	import plsc_pkg::*;

	logic [INT_BITS-1:0]  period_int;   // Integer part of sample period
	logic [FRAC_BITS-1:0] period_frac;  // Fraction part of sample period
	logic                 sample;       // One pulse per sample instant
	logic [TS_BITS-1:0]   ts_count;     // Sample count timestamp

	modport loop  (output period_int, output period_frac, input sample, input ts_count);
	modport timer (input period_int, input period_frac, output sample, output ts_count);
endinterface

//--- plsc_sample_timer.sv
// Sample timer: reloadable down counter with fractional carry and timestamp count.
// Assumes period_int is at least two and is driven from flip-flops.
module plsc_sample_timer
	import plsc_pkg::*;
(
	input wire logic     clk,
	input wire logic     rst,
	input wire logic     ce,
	plsc_period_if.timer pif
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	logic [15:0] cnt_reg;       // Down counter
	logic [15:0] hold_reg;      // Integer part for rest of group
	logic [15:0] frac_acc_reg;  // Running fractional total
	logic [1:0]  sub_reg;       // Sample index within group of four
	logic        sample_reg;    // Sample pulse
	logic [7:0]  ts_reg;        // Timestamp counter

	wire logic        expire_w   = (cnt_reg == CNT_LAST);
	wire logic        reload_w   = expire_w && (sub_reg == SUB_LAST);
	wire logic [16:0] frac_sum_w = {1'b0, frac_acc_reg} + {1'b0, pif.period_frac};
	wire logic        carry_w    = frac_sum_w[16];

	// -------------------------------------------------------------
	// Counter, fraction and timestamp
	// -------------------------------------------------------------
	// Fraction total only moves at a reload, never cleared by a new period
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg      <= NOMINAL_INT;
			hold_reg     <= NOMINAL_INT;
			frac_acc_reg <= 16'h0000;
			sub_reg      <= 2'h0;
			sample_reg   <= 1'b0;
			ts_reg       <= 8'h00;
		end else if (ce) begin
			sample_reg <= expire_w;
			if (expire_w) begin
				ts_reg  <= ts_reg + 8'h01;
				sub_reg <= sub_reg + 2'h1;
			end
			if (reload_w) begin
				// no clear on a new period
				frac_acc_reg <= frac_sum_w[15:0];
				hold_reg     <= pif.period_int;
				cnt_reg      <= pif.period_int + 16'(carry_w);
			end else if (expire_w) begin
				cnt_reg <= hold_reg;
			end else begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
		end
	end

	assign pif.sample   = sample_reg;
	assign pif.ts_count = ts_reg;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	AST_HOLD_IN_GROUP: assert property (@(posedge clk) disable iff (rst)
		ce && expire_w && !reload_w |=> cnt_reg == $past(hold_reg))
		else $error("Counter reloaded inside a group of four");
	AST_CARRY_ONCE: assert property (@(posedge clk) disable iff (rst)
		ce && reload_w |=> cnt_reg == $past(pif.period_int) + 16'($past(carry_w)))
		else $error("Reload value does not match integer plus carry");
	AST_FRAC_KEPT: assert property (@(posedge clk) disable iff (rst)
		!(ce && reload_w) |=> frac_acc_reg == $past(frac_acc_reg))
		else $error("Fraction total changed outside a reload");
	AST_TS_WRAP: assert property (@(posedge clk) disable iff (rst)
		ce && expire_w && ts_reg == TS_LAST |=> ts_reg == 8'h00 && sub_reg == 2'h0)
		else $error("Timestamp wrap not aligned to a reload");

endmodule // plsc_sample_timer

//--- plsc_top.sv
// Phase locked sample clock: loop filter, source selection, timestamp exchange.
// Assumes every input comes from logic on CLK; deviations are Q16.16 counts.

module plsc_top
	import plsc_pkg::*;
#(
	parameter logic [31:0] LOCK_THRESH_Q    = 32'h0001_0000,  // Lock threshold, Q16.16
	parameter int unsigned SLOW_EXEC_CYCLES = 3               // Cycles per run, slow link
)(
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire logic               CE,
	input  wire logic signed [31:0] CURR_DEV,
	input  wire logic               CURR_SUFFICIENT,
	input  wire logic signed [31:0] FREQ_DEV,
	input  wire logic               FREQ_AVAIL,
	input  wire logic               PP_VALID,
	input  wire logic        [7:0]  PP_T3,
	input  wire logic        [7:0]  PP_T2,
	input  wire logic        [7:0]  PP_T1,
	input  wire logic        [7:0]  PP_T0,
	input  wire logic               SLOW_LINK,
	input  wire logic               STAMP_REQ,
	output logic                    SAMPLE,
	output logic             [7:0]  TS_COUNT,
	output logic             [3:0]  SEQ_NUM,
	output logic             [7:0]  STAMP,
	output logic signed      [11:0] RTD,
	output logic                    USE_CURRENT,
	output logic                    LOCKED,
	output logic             [15:0] PERIOD_INT,
	output logic             [15:0] PERIOD_FRAC
);

	// -------------------------------------------------------------
	// Timer
	// -------------------------------------------------------------
	// The timer owns the sample strobe and the sample count; this level
	// only supplies the period halves and reads back the strobe and the count.
	plsc_period_if pif ();

	plsc_sample_timer u_timer (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.pif (pif.timer)
	);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	logic        [31:0] period_reg;    // Desired period, Q16.16
	logic signed [71:0] integ_reg;     // Shared integrator, Q.48
	logic signed [11:0] rtd_reg;       // Round trip delay, ticks
	logic signed [11:0] theta2_reg;    // Clock offset times two, ticks
	logic        [7:0]  stamp_reg;     // Captured timestamp
	logic        [1:0]  cyc_cnt_reg;   // Cycle count for slow link
	logic               use_curr_reg;  // Source used at last run
	logic               locked_reg;    // Lock flag

	// -------------------------------------------------------------
	// Timestamp exchange
	// -------------------------------------------------------------
	// Stamps arrive as a full set of four, newest in PP_T0
	// Twelve bits leave room for the 256 corrections and the sign
	// Differences taken wide so negative values survive
	wire logic signed [11:0] pp_a_w = $signed({4'h0, PP_T2}) - $signed({4'h0, PP_T3});
	wire logic signed [11:0] pp_b_w = $signed({4'h0, PP_T0}) - $signed({4'h0, PP_T1});
	// remote clock rolled between its two stamps
	wire logic pp_roll_remote_w = (PP_T2 > PP_T1);
	// local clock rolled between its two stamps
	wire logic pp_roll_local_w  = (PP_T3 > PP_T0);
	wire logic signed [11:0] pp_rd_fix_w =
		(pp_roll_remote_w ? -ROLL_DELAY : 12'sh000) + (pp_roll_local_w ? ROLL_DELAY : 12'sh000);
	// Offset held doubled, so its fix is doubled too
	wire logic signed [11:0] pp_of_fix_w =
		(pp_roll_remote_w ? -(ROLL_OFFSET <<< 1) : 12'sh000)
		+ (pp_roll_local_w ? (ROLL_OFFSET <<< 1) : 12'sh000);
	wire logic signed [11:0] pp_delta_w  = pp_a_w + pp_b_w + pp_rd_fix_w;
	wire logic signed [11:0] pp_theta2_w = pp_a_w - pp_b_w + pp_of_fix_w;

	// timestamp result refreshed on every exchange
	always_ff @(posedge CLK) begin
		if (RST) begin
			rtd_reg    <= 12'sh000;
			theta2_reg <= 12'sh000;
		end else if (CE && PP_VALID) begin
			rtd_reg    <= pp_delta_w;
			theta2_reg <= pp_theta2_w;
		end
	end

	// One tick is one nominal sample period of oscillator counts
	// Halving here undoes the doubled offset held in theta2_reg
	// Ticks to counts; saturates since a stale offset may be huge
	wire logic signed [44:0] pp_prod_w  = 45'(theta2_reg) * $signed({1'b0, NOMINAL_PERIOD_Q});
	wire logic signed [44:0] pp_half_w  = pp_prod_w >>> 1;
	wire logic signed [31:0] pp_phase_w =
		(pp_half_w > PHASE_MAX_Q) ? PHASE_MAX_Q[31:0] :
		(pp_half_w < PHASE_MIN_Q) ? PHASE_MIN_Q[31:0] : pp_half_w[31:0];

	// -------------------------------------------------------------
	// Source selection
	// -------------------------------------------------------------
	// Timestamp path has the wider range, so it vets the current path
	// Half a cycle is 32 ticks; the offset is doubled, hence 64
	// Offset starts at zero, so the current path is trusted from reset
	// timestamp offset within half a cycle
	wire logic pp_in_range_w = plsc_abs32(32'(theta2_reg)) < HALF_CYCLE_X2;
	wire logic use_curr_w    = CURR_SUFFICIENT && pp_in_range_w;
	wire logic signed [31:0] phase_sel_w = use_curr_w ? CURR_DEV : pp_phase_w;
	wire logic signed [31:0] freq_sel_w  = FREQ_AVAIL ? FREQ_DEV : 32'sh0000_0000;

	// -------------------------------------------------------------
	// Execution rate
	// -------------------------------------------------------------
	// A cycle starts at the sample whose count is a multiple of 64
	// The strobe is one enabled edge long, so CE low cannot repeat a run
	wire logic cycle_end_w = pif.sample && (pif.ts_count[CYC_BITS-1:0] == CYCLE_FIRST);
	wire logic cyc_last_w  = (cyc_cnt_reg == 2'(SLOW_EXEC_CYCLES - 1));
	// every cycle fast, every third slow
	wire logic exec_w      = cycle_end_w && (!SLOW_LINK || cyc_last_w);

	// Counts whole cycles between slow-link runs
	always_ff @(posedge CLK) begin
		if (RST) begin
			cyc_cnt_reg <= 2'h0;
		end else if (CE && cycle_end_w) begin
			cyc_cnt_reg <= cyc_last_w ? 2'h0 : cyc_cnt_reg + 2'h1;
		end
	end

	// -------------------------------------------------------------
	// Loop filter
	// -------------------------------------------------------------
	// Fixed point: deviations Q16.16, gains Q0.32, products Q.48
	// The shift by GAIN_SHIFT brings the sum back to Q16.16 counts
	// Wide accumulator so a long drift saturates nothing silently
	// gains are package constants from the time constants
	// ten second phase constant, critically damped
	wire logic signed [71:0] prop_w =
		72'(phase_sel_w) * 72'($signed({1'b0, PROPORTIONAL_GAIN_Q}));
	// input scaled by the 1/60 second step
	wire logic signed [71:0] int_w  =
		72'(phase_sel_w) * 72'($signed({1'b0, INTEGRAL_GAIN_Q}));
	wire logic signed [71:0] frq_raw_w =
		72'(freq_sel_w) * 72'($signed({1'b0, FREQUENCY_GAIN_Q}));
	// Clamp is per run, so a large frequency error is followed slowly
	// clamp frequency contribution per run
	wire logic signed [71:0] frq_w =
		(frq_raw_w > SLEW_LIMIT_I) ? SLEW_LIMIT_I :
		(frq_raw_w < -SLEW_LIMIT_I) ? -SLEW_LIMIT_I : frq_raw_w;
	// one accumulator for both integral paths
	wire logic signed [71:0] integ_next_w = integ_reg + int_w + frq_w;
	wire logic signed [71:0] adj_w = (integ_next_w + prop_w) >>> GAIN_SHIFT;
	// No period clamp: a runaway loop is left to the lock flag
	wire logic [31:0] period_next_w = NOMINAL_PERIOD_Q + adj_w[31:0];

	// Skipped slow-link cycles add nothing to the integral
	// unit delay holds the integral
	always_ff @(posedge CLK) begin
		if (RST) begin
			integ_reg <= 72'sh0;
		end else if (CE && exec_w) begin
			integ_reg <= integ_next_w;
		end
	end

	// timer picks it up at its next reload
	always_ff @(posedge CLK) begin
		if (RST) begin
			period_reg <= NOMINAL_PERIOD_Q;
		end else if (CE && exec_w) begin
			period_reg <= period_next_w;
		end
	end

	// Plain magnitude test with no hysteresis: a deviation sitting near
	// the threshold may toggle the flag from one run to the next
	// lock tracks the selected deviation size
	always_ff @(posedge CLK) begin
		if (RST) begin
			locked_reg   <= 1'b0;
			use_curr_reg <= 1'b0;
		end else if (CE && exec_w) begin
			locked_reg   <= plsc_abs32(phase_sel_w) < LOCK_THRESH_Q;
			use_curr_reg <= use_curr_w;
		end
	end

	// Timer reads these only at its reload edge, so a run in mid group
	// cannot stretch the samples already being counted
	// integer and fraction halves to the timer
	assign pif.period_int  = period_reg[31:16];
	assign pif.period_frac = period_reg[15:0];

	// -------------------------------------------------------------
	// Timestamp capture and outputs
	// -------------------------------------------------------------
	// snapshot the counter as it stands
	always_ff @(posedge CLK) begin
		if (RST) begin
			stamp_reg <= 8'h00;
		end else if (CE && STAMP_REQ) begin
			stamp_reg <= pif.ts_count;
		end
	end

	// Every output comes from a register here or in the timer
	// stamp and sequence leave on separate ports
	assign STAMP       = stamp_reg;
	// sequence is the count's top bits
	assign SEQ_NUM     = pif.ts_count[TS_BITS-1:TS_BITS-SEQ_BITS];
	assign TS_COUNT    = pif.ts_count;
	assign SAMPLE      = pif.sample;
	assign RTD         = rtd_reg;
	assign USE_CURRENT = use_curr_reg;
	assign LOCKED      = locked_reg;
	assign PERIOD_INT  = period_reg[31:16];
	assign PERIOD_FRAC = period_reg[15:0];

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	AST_START_NOMINAL: assert property (@(posedge CLK)
		RST |=> period_reg == NOMINAL_PERIOD_Q && integ_reg == 72'sh0)
		else $error("Period not nominal after reset");
	AST_PERIOD_ONLY_ON_RUN: assert property (@(posedge CLK) disable iff (RST)
		!(CE && exec_w) |=> $stable(period_reg))
		else $error("Period changed outside a filter run");
	AST_SLOW_SKIP: assert property (@(posedge CLK) disable iff (RST)
		SLOW_LINK && CE && cycle_end_w && !cyc_last_w |=> $stable(integ_reg))
		else $error("Filter ran on a skipped cycle");
	AST_STAMP_DIRECT: assert property (@(posedge CLK) disable iff (RST)
		CE && STAMP_REQ |=> STAMP == $past(pif.ts_count))
		else $error("Stamp differs from sample count");
	AST_DELAY_ROLL: assert property (@(posedge CLK) disable iff (RST)
		CE && PP_VALID && pp_roll_remote_w && !pp_roll_local_w
		|=> RTD == $past(pp_a_w) + $past(pp_b_w) - ROLL_DELAY)
		else $error("Remote rollover not corrected by 256");
	AST_SRC_NEEDS_CURRENT: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w && !CURR_SUFFICIENT |=> !USE_CURRENT)
		else $error("Current source chosen without enough current");

	// Timestamp exchange and capture: local delay and remote offset rollover, and holding
	AST_LOCAL_ROLL: assert property (@(posedge CLK) disable iff (RST)
		CE && PP_VALID && pp_roll_local_w && !pp_roll_remote_w
		|=> RTD == $past(pp_a_w) + $past(pp_b_w) + ROLL_DELAY)
		else $error("Local rollover not corrected by 256");
	AST_OFFSET_ROLL: assert property (@(posedge CLK) disable iff (RST)
		CE && PP_VALID && pp_roll_remote_w && !pp_roll_local_w
		|=> theta2_reg == $past(pp_a_w) - $past(pp_b_w) - (ROLL_OFFSET <<< 1))
		else $error("Remote rollover not corrected by 128 in the offset");
	AST_RTD_HELD: assert property (@(posedge CLK) disable iff (RST)
		!(CE && PP_VALID) |=> $stable(RTD))
		else $error("Round trip delay changed without a stamp set");
	AST_STAMP_HELD: assert property (@(posedge CLK) disable iff (RST)
		!(CE && STAMP_REQ) |=> $stable(STAMP))
		else $error("Stamp changed without a request");

	// Loop filter: source choice, shared integrator, slew and lock
	AST_SRC_FOLLOWS: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w |=> USE_CURRENT == $past(CURR_SUFFICIENT && pp_in_range_w))
		else $error("Source choice does not follow current validity");
	AST_USE_NEEDS_RANGE: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w && !pp_in_range_w |=> !USE_CURRENT)
		else $error("Current source chosen with offset out of range");
	AST_INTEG_ON_RUN: assert property (@(posedge CLK) disable iff (RST)
		!(CE && exec_w) |=> $stable(integ_reg))
		else $error("Integrator moved outside a filter run");
	AST_FREQ_ZERO: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w && !FREQ_AVAIL |=> integ_reg == $past(integ_reg) + $past(int_w))
		else $error("Frequency path active without a measurement");
	AST_SLEW_BOUND: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w |=> integ_reg - $past(integ_reg) - $past(int_w) <= SLEW_LIMIT_I
		&& integ_reg - $past(integ_reg) - $past(int_w) >= -SLEW_LIMIT_I)
		else $error("Frequency step exceeds the slew limit");
	AST_LOCK_RULE: assert property (@(posedge CLK) disable iff (RST)
		CE && exec_w |=> LOCKED == ($past(plsc_abs32(phase_sel_w)) < LOCK_THRESH_Q))
		else $error("Lock flag does not match deviation size");

endmodule // plsc_top

//--- plsc_peer_model.sv
// Peer terminal model: hands the device complete sets of four time stamps.
// Assumes the device samples a set on the rising CLK edge after a falling-edge drive.
module plsc_peer_model
	import plsc_pkg::*;
(
	input  wire logic          clk,
	output logic               pp_valid,
	output logic [TS_BITS-1:0] pp_t3,
	output logic [TS_BITS-1:0] pp_t2,
	output logic [TS_BITS-1:0] pp_t1,
	output logic [TS_BITS-1:0] pp_t0
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Idle state at time zero
	// ------------------------------------------------------------
	initial begin
		pp_valid = 1'b0;
		pp_t3    = 8'h00;
		pp_t2    = 8'h00;
		pp_t1    = 8'h00;
		pp_t0    = 8'h00;
	end

	// stamps only, no sequence
	// One full set per call, oldest first; stale stamps inverted afterwards
	task automatic send(input logic [7:0] t3, input logic [7:0] t2,
		input logic [7:0] t1, input logic [7:0] t0);
		@(negedge clk);
		pp_valid = 1'b1;
		pp_t3    = t3;
		pp_t2    = t2;
		pp_t1    = t1;
		pp_t0    = t0;
		@(negedge clk);
		// Stamps are no longer valid, so show garbage rather than hold
		pp_valid = 1'b0;
		pp_t3    = ~t3;
		pp_t2    = ~t2;
		pp_t1    = ~t1;
		pp_t0    = ~t0;
	endtask
endmodule // plsc_peer_model

//--- tb_top.sv
// Self-checking bench for the phase locked sample clock.
// Assumes a 20 MHz clock; filter runs are too far apart to reach here.
module tb_top
	import plsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic               clk, rst, ce, stamp_req;   // Clock, controls
	logic signed [31:0] curr_dev, freq_dev;        // Held deviations
	logic               curr_sufficient, freq_avail, slow_link;
	logic               pp_valid, sample, use_current, locked;
	logic        [7:0]  pp_t3, pp_t2, pp_t1, pp_t0; // Peer stamps
	logic        [7:0]  ts_count, stamp;           // Sample count, capture
	logic        [3:0]  seq_num;                   // Sequence number
	logic signed [11:0] rtd;                       // Round trip delay
	logic        [15:0] period_int, period_frac;   // Desired period
	int                 n_errors, checks, s_idx;   // Counters, sample index
	longint             cyc, last_cyc;             // Free cycle count
	logic        [15:0] frac_acc;                  // Model of fraction sum
	logic               carry_pend;                // Next period gets one more

	plsc_top i_dut (.CLK(clk), .RST(rst), .CE(ce), .CURR_DEV(curr_dev),
		.CURR_SUFFICIENT(curr_sufficient), .FREQ_DEV(freq_dev), .FREQ_AVAIL(freq_avail),
		.PP_VALID(pp_valid), .PP_T3(pp_t3), .PP_T2(pp_t2), .PP_T1(pp_t1), .PP_T0(pp_t0),
		.SLOW_LINK(slow_link), .STAMP_REQ(stamp_req), .SAMPLE(sample), .TS_COUNT(ts_count),
		.SEQ_NUM(seq_num), .STAMP(stamp), .RTD(rtd), .USE_CURRENT(use_current),
		.LOCKED(locked), .PERIOD_INT(period_int), .PERIOD_FRAC(period_frac));

	plsc_peer_model i_peer (.clk(clk), .pp_valid(pp_valid), .pp_t3(pp_t3),
		.pp_t2(pp_t2), .pp_t1(pp_t1), .pp_t0(pp_t0));

	// ------------------------------------------------------------
	// Clock and cycle counter
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Counting edges avoids relying on where a task happened to wait
	always @(posedge clk) cyc++;

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Waits for the next sample; extra is cycles frozen by CE meanwhile
	task automatic next_sample(input int extra);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sample !== 1'b1 && n < 20000);
		// Bounded wait: a lost sample ends the run
		if (sample !== 1'b1) begin
			n_errors++;
			end_sim();
		end
		s_idx++;
		if (s_idx > 1) chk(32'(cyc - last_cyc), 32'(NOMINAL_INT) + 32'(carry_pend) + 32'(extra));
		last_cyc = cyc;
		chk(32'(ts_count), 32'(s_idx[7:0]));
		chk(32'(seq_num), 32'(s_idx[7:4]));
		// Fraction is added at every fourth sample; its carry lengthens one period
		if (s_idx % 4 == 0) begin
			{carry_pend, frac_acc} = 17'(frac_acc) + 17'(NOMINAL_PERIOD_Q[15:0]);
		end else begin
			carry_pend = 1'b0;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// start-up values
	task automatic t_reset_values();
		chk(32'(period_int), 32'(NOMINAL_PERIOD_Q[31:16]));
		chk(32'(period_frac), 32'(NOMINAL_PERIOD_Q[15:0]));
		chk({ts_count, stamp, 4'h0, seq_num, 6'h00, locked, use_current}, 32'h0);
		chk(32'(sample), 32'h0);
	endtask

	task automatic t_round_trip();
		logic [7:0] tab [4][4];
		int         e;
		tab = '{'{8'h0a, 8'h14, 8'h1e, 8'h2d}, '{8'h10, 8'hfe, 8'h03, 8'h18},
			'{8'hfc, 8'h40, 8'h42, 8'h04}, '{8'hfe, 8'hff, 8'h01, 8'h03}};
		foreach (tab[i]) begin
			i_peer.send(tab[i][0], tab[i][1], tab[i][2], tab[i][3]);
			e = int'(tab[i][1]) - int'(tab[i][0]) + int'(tab[i][3]) - int'(tab[i][2]);
			if (tab[i][1] > tab[i][2]) e = e - 256;
			if (tab[i][0] > tab[i][3]) e = e + 256;
			chk(32'(rtd), 32'(e));
		end
	endtask

	task automatic t_first_group();
		repeat (4) next_sample(0);
		@(negedge clk);
		chk(32'(sample), 32'h0);
	endtask

	task automatic t_clock_enable();
		repeat (1000) @(negedge clk);
		ce = 1'b0;
		repeat (100) @(negedge clk);
		chk(32'(ts_count), 32'(s_idx[7:0]));
		ce = 1'b1;
		next_sample(100);
	endtask

	task automatic t_stamp_capture();
		repeat (10) @(negedge clk);
		stamp_req = 1'b1;
		@(negedge clk);
		stamp_req = 1'b0;
		chk(32'(stamp), 32'(s_idx[7:0]));
		next_sample(0);
		chk(32'(stamp), 32'(s_idx - 1));
	endtask

	task automatic t_fraction_carry();
		while (s_idx < 17) next_sample(0);
		chk(32'(stamp), 32'h5);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		stamp_req = 1'b0;
		curr_dev = 32'sh0;
		freq_dev = 32'sh0;
		curr_sufficient = 1'b0;
		freq_avail = 1'b0;
		slow_link = 1'b0;
		n_errors = 0;
		checks = 0;
		s_idx = 0;
		cyc = 0;
		last_cyc = 0;
		frac_acc = 16'h0000;
		carry_pend = 1'b0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_reset_values();
		t_round_trip();
		t_first_group();
		t_clock_enable();
		t_stamp_capture();
		t_fraction_carry();
		end_sim();
	end
endmodule // tb_top
